// ==== hw/vcb_top.sv ====
// Configuration registers, load port and bypass delays of the converter.
`timescale 1ns/100ps
// Operation
// - Decode input and output format fields
// - Bit 4 picks filter or matrix first
// - Decode filter modes for channels B, C
// - Bit 9 keeps only first section
// - Decode LUT placement per channel
// - Key blanking only when enabled
// - Bypass W output channel select
// - LUT address window from data word
// - Input and output bias disable bits
// - Four channels always feed core delays
// - Common core delay, field plus two
// - Core bypass skips processing, feeds mux
// - Bypass low shows data at second edge
// - Filter bypass channel takes delayed data
// - Channels A and key always delayed
// - Filter delay lengths from regs 3-6
// - Address taken on first low strobe
// - Register written after its last word
// - Pause holds the load interface
// - First-op trims latency 35 or 6
module vcb_top
  import vcb_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic load_strobe_n,
  input wire logic pause,
  input wire logic [12:0] coefficient_port,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [12:0] in_a,
  input wire logic [12:0] in_b,
  input wire logic [12:0] in_c,
  input wire logic [12:0] in_d,
  input wire logic bypass_select_n,
  input wire logic horizontal_blank_flag,
  input wire logic [12:0] core_w,
  input wire logic [12:0] core_x,
  input wire logic [12:0] core_y,
  input wire logic [12:0] core_z,
  input wire logic [12:0] hbf_b_in,
  input wire logic [12:0] hbf_c_in,
  output logic out_valid,
  input wire logic out_ready,
  output logic [12:0] w_output_port,
  output logic [12:0] x_out,
  output logic [12:0] y_out,
  output logic [12:0] z_out,
  output logic [12:0] fsec_a_out,
  output logic [12:0] fsec_b_out,
  output logic [12:0] fsec_c_out,
  output logic [12:0] fsec_key_out,
  output logic [12:0] key_blanked,
  output logic [9:0] lut_addr_a,
  output logic [9:0] lut_addr_b,
  output logic [9:0] lut_addr_c,
  output logic [3:0] in_fmt_sel,
  output logic [3:0] out_fmt_sel,
  output logic matrix_first,
  output logic [3:0] filt_b_op,
  output logic [3:0] filt_c_op,
  output logic first_op_only,
  output logic [5:0] latency_trim,
  output logic [3:0] lut_a_mode,
  output logic [3:0] lut_b_mode,
  output logic [3:0] lut_c_mode,
  output logic key_horizontal_blank_flag_en,
  output logic [1:0] w_bypass_sel,
  output logic in_bias_en,
  output logic out_bias_en,
  output logic [12:0] blank_level_a,
  output logic [12:0] blank_level_b,
  output logic [12:0] blank_level_c,
  output logic [12:0] blank_level_d
);

  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------
  function automatic logic [3:0] dec4(input logic [1:0] code);
    dec4 = 4'h1 << code;
  endfunction : dec4

  function automatic logic [9:0] lut_window(input logic [12:0] word,
                                            input logic [1:0] sel);
    logic [12:0] sh;
    sh = word >> sel;
    lut_window = sh[9:0];
  endfunction : lut_window

  // Pages this block does not keep still consume their data words so
  // the next address is recognised at the right cycle.
  function automatic logic [10:0] words_for(input logic [12:0] addr);
    logic [4:0] pg;
    pg = addr[12:8];
    if (pg == `VCB_PG_COEF) begin
      words_for = `VCB_N_COEF;
    end else if (pg >= `VCB_PG_LUT_A && pg <= `VCB_PG_LUT_C) begin
      words_for = `VCB_N_LUT;
    end else if (pg == `VCB_PG_HF0 || pg == `VCB_PG_HF1) begin
      words_for = `VCB_N_HF;
    end else if (pg >= `VCB_PG_RSL_LO && pg <= `VCB_PG_RSL_HI) begin
      words_for = `VCB_N_RSL;
    end else begin
      words_for = `VCB_N_ONE;
    end
  endfunction : words_for

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  vcb_state_s s_r;
  vcb_state_s s_nxt;
  logic adv;
  logic pop;
  logic [3:0][12:0] dly_core;
  logic [3:0][12:0] dly_fsec;
  logic [7:0][6:0] rd_addr;
  logic [51:0] out_word;
  logic [12:0] w_byp;

  assign in_ready = (s_r.buf_cnt != 2'h2);
  assign adv = in_valid && in_ready;
  assign pop = (s_r.buf_cnt != 2'h0) && out_ready;

  // ---------------------------------------------------------------
  // Delay lines
  // ---------------------------------------------------------------
  // All eight lines share one write pointer; the four core lines read
  // one common distance behind it, each filter line its own.
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_dly
      logic [6:0] len;
      logic [12:0] rd;
      if (g < 4) begin : g_core
        assign len = s_r.core_len[6:0];
        assign dly_core[g] = rd;
      end else begin : g_fsec
        assign len = s_r.fd_len[g-4][6:0];
        assign dly_fsec[g-4] = rd;
      end
      assign rd_addr[g] = s_r.wp - len;
      vcb_dly_ram u_ram (
        .clk(clk),
        .we(adv),
        .waddr(s_r.wp),
        .wdata(s_r.in_d[g%4]),
        .raddr(rd_addr[g]),
        .rdata(rd)
      );
    end
  endgenerate

  // The bypass words skip every processing stage and meet the core
  // results only here, in front of the output buffer.
  assign w_byp = dly_core[s_r.cfg1[8:7]];
  assign out_word = s_r.byp_n ? {core_w, core_x, core_y, core_z}
                              : {w_byp, dly_core[1], dly_core[2],
                                 dly_core[3]};

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;

    // Load port.
    if (load_strobe_n) begin
      s_nxt.ld = VCB_LD_ADDR;
    end else if (!pause) begin
      unique case (s_r.ld)
        VCB_LD_ADDR: begin
          s_nxt.ld_addr = coefficient_port;
          s_nxt.ld_left = words_for(coefficient_port);
          s_nxt.ld = VCB_LD_DATA;
        end
        VCB_LD_DATA: begin
          s_nxt.ld_left = s_r.ld_left - 11'h001;
          if (s_r.ld_left == 11'h001) begin
            s_nxt.ld = VCB_LD_ADDR;
            // Reserved bits are masked so they always read as zero.
            case (s_r.ld_addr)
              `VCB_A_CFG0:
                s_nxt.cfg0 = coefficient_port & `VCB_CFG0_MASK;
              `VCB_A_CFG1:
                s_nxt.cfg1 = coefficient_port & `VCB_CFG1_MASK;
              `VCB_A_CORE:
                s_nxt.core_len = coefficient_port & `VCB_LEN_MASK;
              `VCB_A_FD_A:
                s_nxt.fd_len[0] = coefficient_port & `VCB_LEN_MASK;
              `VCB_A_FD_B:
                s_nxt.fd_len[1] = coefficient_port & `VCB_LEN_MASK;
              `VCB_A_FD_C:
                s_nxt.fd_len[2] = coefficient_port & `VCB_LEN_MASK;
              `VCB_A_FD_K:
                s_nxt.fd_len[3] = coefficient_port & `VCB_LEN_MASK;
              `VCB_A_BLK_A: s_nxt.blank[0] = coefficient_port;
              `VCB_A_BLK_B: s_nxt.blank[1] = coefficient_port;
              `VCB_A_BLK_C: s_nxt.blank[2] = coefficient_port;
              `VCB_A_BLK_D: s_nxt.blank[3] = coefficient_port;
              default: ;
            endcase
          end
        end
      endcase
    end

    // Video path; everything stands still while the buffer is full.
    if (adv) begin
      s_nxt.in_d = {in_d, in_c, in_b, in_a};
      s_nxt.wp = s_r.wp + 7'h01;
      s_nxt.byp_n = bypass_select_n;
      s_nxt.fsec[0] = dly_fsec[0];
      s_nxt.fsec[1] = (s_r.cfg0[6:5] == `VCB_FILT_BYP) ?
                      dly_fsec[1] : hbf_b_in;
      s_nxt.fsec[2] = (s_r.cfg0[8:7] == `VCB_FILT_BYP) ?
                      dly_fsec[2] : hbf_c_in;
      s_nxt.fsec[3] = dly_fsec[3];
      for (int i = 0; i < 3; i++) begin
        s_nxt.lut_addr[i] = lut_window(s_r.in_d[i],
                                       s_r.cfg1[10:9]);
      end
      s_nxt.key_out = (horizontal_blank_flag &&
                       s_r.cfg1[`VCB_KEY_BLK_BIT]) ?
                      s_r.blank[3] : s_r.in_d[3];
    end

    // Two-entry output buffer.
    if (adv) begin
      s_nxt.buf_q[s_r.buf_wp] = out_word;
      s_nxt.buf_wp = ~s_r.buf_wp;
    end
    if (pop) begin
      s_nxt.buf_rp = ~s_r.buf_rp;
    end
    s_nxt.buf_cnt = s_r.buf_cnt + {1'b0, adv} - {1'b0, pop};
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign out_valid = (s_r.buf_cnt != 2'h0);
  assign {w_output_port, x_out, y_out, z_out} = s_r.buf_q[s_r.buf_rp];
  assign fsec_a_out = s_r.fsec[0];
  assign fsec_b_out = s_r.fsec[1];
  assign fsec_c_out = s_r.fsec[2];
  assign fsec_key_out = s_r.fsec[3];
  assign key_blanked = s_r.key_out;
  assign lut_addr_a = s_r.lut_addr[0];
  assign lut_addr_b = s_r.lut_addr[1];
  assign lut_addr_c = s_r.lut_addr[2];

  // One-hot decodes; bit 0 set marks the reserved format code.
  assign in_fmt_sel = dec4(s_r.cfg0[1:0]);
  assign out_fmt_sel = dec4(s_r.cfg0[3:2]);
  assign matrix_first = s_r.cfg0[`VCB_ARR_BIT];
  assign filt_b_op = dec4(s_r.cfg0[6:5]);
  assign filt_c_op = dec4(s_r.cfg0[8:7]);
  assign first_op_only = s_r.cfg0[`VCB_FIRST_BIT];
  // With the matrix first the filter is the section dropped.
  assign latency_trim = !first_op_only ? `VCB_TRIM_NONE :
                        matrix_first ? `VCB_TRIM_FILT :
                        `VCB_TRIM_MAT;
  assign lut_a_mode = dec4(s_r.cfg1[1:0]);
  assign lut_b_mode = dec4(s_r.cfg1[3:2]);
  assign lut_c_mode = dec4(s_r.cfg1[5:4]);
  assign key_horizontal_blank_flag_en = s_r.cfg1[`VCB_KEY_BLK_BIT];
  assign w_bypass_sel = s_r.cfg1[8:7];
  assign in_bias_en = !s_r.cfg1[`VCB_IBIAS_BIT];
  assign out_bias_en = !s_r.cfg1[`VCB_OBIAS_BIT];
  assign blank_level_a = s_r.blank[0];
  assign blank_level_b = s_r.blank[1];
  assign blank_level_c = s_r.blank[2];
  assign blank_level_d = s_r.blank[3];
endmodule : vcb_top

// ==== hw/vcb_params.svh ====
// Constants for the video configuration and bypass delay block.
`ifndef VCB_PARAMS_SVH
`define VCB_PARAMS_SVH

`define VCB_W 13
`define VCB_PTR_W 7
`define VCB_DEPTH 128
`define VCB_BUF_W 52

// -----------------------------------------------------------------
// Register addresses on the load port
// -----------------------------------------------------------------
`define VCB_A_CFG0 13'h0200
`define VCB_A_CFG1 13'h0201
`define VCB_A_CORE 13'h0202
`define VCB_A_FD_A 13'h0203
`define VCB_A_FD_B 13'h0204
`define VCB_A_FD_C 13'h0205
`define VCB_A_FD_K 13'h0206
`define VCB_A_BLK_A 13'h0207
`define VCB_A_BLK_B 13'h0208
`define VCB_A_BLK_C 13'h0209
`define VCB_A_BLK_D 13'h020a

// -----------------------------------------------------------------
// Address pages and the data words each one expects
// -----------------------------------------------------------------
`define VCB_PG_COEF 5'h00
`define VCB_PG_LUT_A 5'h03
`define VCB_PG_LUT_C 5'h05
`define VCB_PG_HF0 5'h0c
`define VCB_PG_HF1 5'h0d
`define VCB_PG_RSL_LO 5'h0e
`define VCB_PG_RSL_HI 5'h13
`define VCB_N_ONE 11'h001
`define VCB_N_HF 11'h002
`define VCB_N_RSL 11'h004
`define VCB_N_COEF 11'h00a
`define VCB_N_LUT 11'h400

// -----------------------------------------------------------------
// Field masks, positions, codes and latency figures
// -----------------------------------------------------------------
`define VCB_CFG0_MASK 13'h03ff
`define VCB_CFG1_MASK 13'h1fff
`define VCB_LEN_MASK 13'h007f
`define VCB_FILT_BYP 2'h3
`define VCB_ARR_BIT 4
`define VCB_FIRST_BIT 9
`define VCB_KEY_BLK_BIT 6
`define VCB_IBIAS_BIT 11
`define VCB_OBIAS_BIT 12
`define VCB_TRIM_FILT 6'h23
`define VCB_TRIM_MAT 6'h06
`define VCB_TRIM_NONE 6'h00

`endif

// ==== hw/vcb_pkg.sv ====
// Types shared by the video configuration and bypass delay block.
package vcb_pkg;
`include "vcb_params.svh"

  typedef enum logic {VCB_LD_ADDR, VCB_LD_DATA} vcb_ld_e;

  typedef struct packed {
    vcb_ld_e ld;
    logic [12:0] ld_addr;
    logic [10:0] ld_left;
    logic [12:0] cfg0;
    logic [12:0] cfg1;
    logic [12:0] core_len;
    logic [3:0][12:0] fd_len;
    logic [3:0][12:0] blank;
    logic [6:0] wp;
    logic [3:0][12:0] in_d;
    logic byp_n;
    logic [3:0][12:0] fsec;
    logic [2:0][9:0] lut_addr;
    logic [12:0] key_out;
    logic [1:0][51:0] buf_q;
    logic buf_rp;
    logic buf_wp;
    logic [1:0] buf_cnt;
  } vcb_state_s;
endpackage : vcb_pkg

// ==== hw/vcb_dly_ram.sv ====
// One 128-word delay line memory with a registered read port.
`timescale 1ns/100ps
module vcb_dly_ram
  import vcb_pkg::*;
(
  input wire logic clk,
  input wire logic we,
  input wire logic [6:0] waddr,
  input wire logic [12:0] wdata,
  input wire logic [6:0] raddr,
  output logic [12:0] rdata
);
  logic [12:0] mem [0:`VCB_DEPTH-1];

  // Read happens only with a write so a stall freezes the line.
  // Reading the address being written returns the new word, which
  // gives the shortest delay of two cycles.
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
      rdata <= (raddr == waddr) ? wdata : mem[raddr];
    end
  end
endmodule : vcb_dly_ram

// ==== sim/vcb_top_asserts.sv ====
// Checker for the decodes, load port and output buffer of vcb_top.
`timescale 1ns/100ps
module vcb_chk
  import vcb_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic load_strobe_n,
  input wire logic pause,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic horizontal_blank_flag,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [12:0] w_output_port,
  input wire logic [12:0] key_blanked,
  input wire logic [12:0] blank_level_d,
  input wire logic [3:0] in_fmt_sel,
  input wire logic [3:0] out_fmt_sel,
  input wire logic [3:0] filt_b_op,
  input wire logic [3:0] filt_c_op,
  input wire logic matrix_first,
  input wire logic first_op_only,
  input wire logic [5:0] latency_trim,
  input wire logic key_horizontal_blank_flag_en,
  input wire logic [1:0] w_bypass_sel
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  AST_TRIM: assert property (
    latency_trim == (first_op_only ? (matrix_first ? 6'h23 : 6'h06) : 6'h00))
    else $error("latency trim wrong");
  AST_FMT: assert property (
    $onehot(in_fmt_sel) && $onehot(out_fmt_sel))
    else $error("format decode not one-hot");
  AST_FILT: assert property (
    $onehot(filt_b_op) && $onehot(filt_c_op))
    else $error("filter decode not one-hot");
  AST_HOLD: assert property (
    (load_strobe_n || pause) |=> $stable({in_fmt_sel, out_fmt_sel, filt_b_op,
    filt_c_op, matrix_first, key_horizontal_blank_flag_en, w_bypass_sel, blank_level_d}))
    else $error("registers changed while load port idle");
  AST_KEY: assert property (
    in_valid && in_ready && horizontal_blank_flag && key_horizontal_blank_flag_en
    |=> key_blanked == blank_level_d) else $error("key not blanked");
  AST_HEAD: assert property (
    out_valid && !out_ready |=> out_valid && $stable(w_output_port))
    else $error("buffer head lost during stall");
  AST_RST: assert property (
    $rose(reset_n) |-> !out_valid && in_ready) else $error("reset state");
  AST_RDY: assert property (
    !out_valid && in_valid && in_ready |=> out_valid)
    else $error("accepted word not at buffer head");
  cover property (in_valid && !in_ready);
  cover property (pause && !load_strobe_n);
  cover property (horizontal_blank_flag && key_horizontal_blank_flag_en && in_valid);
endmodule : vcb_chk

bind vcb_top vcb_chk u_chk (.*);

// ==== sim/vcb_sink.sv ====
// Video sink model that stalls on command and records popped words.
`timescale 1ns/100ps
module vcb_sink
  import vcb_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic stall,
  input wire logic out_valid,
  output logic out_ready,
  input wire logic [12:0] w_output_port,
  input wire logic [12:0] x_out,
  input wire logic [12:0] y_out,
  input wire logic [12:0] z_out,
  output int n_pop,
  output logic [51:0] last
);
  assign out_ready = !stall;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      n_pop <= 0;
    end else if (out_valid && out_ready) begin
      n_pop <= n_pop + 1;
      last <= {w_output_port, x_out, y_out, z_out};
    end
  end
endmodule : vcb_sink

// ==== sim/tb_video_config_and_bypass_delay.sv ====
// Self-checking testbench for the configuration and bypass delay block.
`timescale 1ns/100ps
`include "vcb_params.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module tb_video_config_and_bypass_delay;
  logic clk = 0, reset_n = 0, load_strobe_n = 1, pause = 0, stall = 0;
  logic in_valid = 0, bypass_select_n = 1, run = 0;
  logic in_ready, out_valid, out_ready, matrix_first, first_op_only;
  logic key_horizontal_blank_flag_en, in_bias_en, out_bias_en, horizontal_blank_flag;
  logic [12:0] coefficient_port = 0, in_a, in_b, in_c, in_d, vi = 0;
  logic [12:0] core_w, core_x, core_y, core_z, hbf_b_in, hbf_c_in;
  logic [12:0] w_output_port, x_out, y_out, z_out, key_blanked;
  logic [12:0] fsec_a_out, fsec_b_out, fsec_c_out, fsec_key_out;
  logic [12:0] blank_level_a, blank_level_b, blank_level_c, blank_level_d;
  logic [9:0] lut_addr_a, lut_addr_b, lut_addr_c;
  logic [3:0] in_fmt_sel, out_fmt_sel, filt_b_op, filt_c_op;
  logic [3:0] lut_a_mode, lut_b_mode, lut_c_mode;
  logic [5:0] latency_trim;
  logic [1:0] w_bypass_sel;
  logic [51:0] last;
  logic [31:0] off, off0;
  int n_pop, errors = 0, n_checks = 0, cyc = 0;
  assign in_a = vi;
  assign in_b = vi + 13'h0064;
  assign in_c = vi + 13'h00c8;
  assign in_d = vi + 13'h012c;
  assign core_w = vi + 13'h0800;
  assign core_x = vi + 13'h0900;
  assign core_y = vi + 13'h0a00;
  assign core_z = vi + 13'h0b00;
  assign hbf_b_in = 13'h0123;
  assign hbf_c_in = 13'h0456;
  assign horizontal_blank_flag = vi[3];
  vcb_top u_dut (.*);
  vcb_sink u_sink (.*);
  always #2.5 clk = ~clk;
  // Word index advances only on accepted words; sink stalls 4 of 16 cycles.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    stall <= cyc[3:2] == 2'h0;
    in_valid <= run;
    if (!reset_n) vi <= 13'h0000;
    else if (in_valid && in_ready) vi <= vi + 13'h0001;
    if (cyc == 20000) begin
      errors++;
      final_report();
    end
  end
  task final_report;
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  task rst;
    @(posedge clk) reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    #1;
  endtask : rst
  task send(input logic [12:0] w);
    @(posedge clk) load_strobe_n <= 1'b0;
    coefficient_port <= w;
  endtask : send
  task rel;
    @(posedge clk) load_strobe_n <= 1'b1;
    #1;
  endtask : rel
  task ld(input logic [12:0] a, input logic [12:0] d);
    send(a);
    send(d);
    rel();
  endtask : ld
  task stream(input int n);
    run <= 1'b1;
    for (int i = 0; i < 4 * n && vi < n; i++) @(posedge clk);
    run <= 1'b0;
    repeat (30) @(posedge clk);
  endtask : stream
  task t_load;
    rst();
    `CHK(in_fmt_sel, 4'h1);
    `CHK({in_bias_en, out_bias_en, latency_trim}, 8'hc0);
    for (int i = 0; i < 4; i++) ld(`VCB_A_BLK_A + 13'(i), 13'h1555 ^ 13'(i));
    `CHK({blank_level_a, blank_level_b, blank_level_c, blank_level_d},
      {13'h1555, 13'h1554, 13'h1557, 13'h1556});
    send(13'h0217);
    send(13'h0aaa);
    send(`VCB_A_BLK_A);
    send(13'h0111);
    send(`VCB_A_BLK_B);
    send(13'h0222);
    send(`VCB_A_BLK_C);
    rel();
    `CHK({blank_level_a, blank_level_b}, {13'h0111, 13'h0222});
    ld(`VCB_A_BLK_D, 13'h0333);
    `CHK({blank_level_c, blank_level_d}, {13'h1557, 13'h0333});
    send(`VCB_A_BLK_D);
    @(posedge clk) pause <= 1'b1;
    coefficient_port <= 13'h0bad;
    @(posedge clk);
    @(posedge clk) pause <= 1'b0;
    coefficient_port <= 13'h0777;
    rel();
    `CHK(blank_level_d, 13'h0777);
  endtask : t_load
  task t_cfg;
    logic [1:0] v;
    for (int i = 0; i < 4; i++) begin
      v = 2'(i);
      ld(`VCB_A_CFG0, {3'h0, v[1], v, v, v[0], v, v});
      `CHK({in_fmt_sel, out_fmt_sel}, {4'h1 << v, 4'h1 << v});
      `CHK({filt_b_op, filt_c_op}, {4'h1 << v, 4'h1 << v});
      `CHK(matrix_first, v[0]);
      `CHK(first_op_only, v[1]);
      `CHK(latency_trim, v[1] ? (v[0] ? 6'h23 : 6'h06) : 6'h00);
      ld(`VCB_A_CFG1, {v[0], v[1], v, v, v[0], v, v, v});
      `CHK({lut_a_mode, lut_b_mode, lut_c_mode},
        {4'h1 << v, 4'h1 << v, 4'h1 << v});
      `CHK(key_horizontal_blank_flag_en, v[0]);
      `CHK(w_bypass_sel, v);
      `CHK({in_bias_en, out_bias_en}, {!v[1], !v[0]});
    end
  endtask : t_cfg
  task t_delay(input logic [6:0] f, input logic [1:0] s, input logic b);
    logic [12:0] k;
    rst();
    ld(`VCB_A_CORE, {6'h00, f});
    ld(`VCB_A_CFG1, {4'h0, s, 1'b1, 6'h00});
    bypass_select_n <= b;
    stream(200);
    off = 32'(n_pop) - 32'(last[38:26]) + 32'd99;
    if (b) begin
      `CHK(last[51:39] + 13'h0100, last[38:26]);
    end else begin
      `CHK(last[51:39], last[38:26] + 13'h0064 * 13'(s) - 13'h0064);
      `CHK(last[25:13], last[38:26] + 13'h0064);
      if (f == 7'h00) off0 = off;
      `CHK(off - off0, 32'(f));
    end
    `CHK(fsec_b_out, hbf_b_in);
    `CHK(fsec_c_out, hbf_c_in);
    `CHK(fsec_key_out - fsec_a_out, 13'h012c);
    `CHK({lut_addr_b - lut_addr_a, lut_addr_c - lut_addr_a},
      {10'h064, 10'h0c8});
    // The last accepted word decides the blank flag of the key word.
    k = 13'(lut_addr_a) + 13'h0001;
    `CHK(key_blanked, k[3] ? blank_level_d : k + 13'h012b);
  endtask : t_delay
  initial begin
    t_load();
    t_cfg();
    t_delay(7'h00, 2'h0, 1'b0);
    t_delay(7'h05, 2'h1, 1'b0);
    t_delay(7'h7f, 2'h3, 1'b0);
    t_delay(7'h00, 2'h2, 1'b1);
    final_report();
  end
endmodule : tb_video_config_and_bypass_delay
